// file: core/rack_cmd_pkg.sv
// Constants shared by the rack command parser and its helpers.
package rack_cmd_pkg;
   // Character codes seen on the serial link.
   localparam logic [7:0] CH_BS = 8'h08;
   localparam logic [7:0] CH_LF = 8'h0A;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_D0 = 8'h30;
   localparam logic [7:0] CH_D9 = 8'h39;
   localparam logic [7:0] CH_COLON = 8'h3A;
   localparam logic [7:0] CH_SEMI = 8'h3B;
   localparam logic [7:0] CH_EQ = 8'h3D;
   localparam logic [7:0] CH_LOW_A = 8'h61;
   localparam logic [7:0] CH_LOW_Z = 8'h7A;
   localparam logic [7:0] CASE_BIT = 8'h20;
   // Command codes, upper case.
   localparam logic [7:0] C_GAIN = 8'h41;
   localparam logic [7:0] C_BACKUP = 8'h42;
   localparam logic [7:0] C_CALIN = 8'h43;
   localparam logic [7:0] C_COUPLE = 8'h44;
   localparam logic [7:0] C_FAULT = 8'h46;
   localparam logic [7:0] C_INSTALL = 8'h49;
   localparam logic [7:0] C_LAMP = 8'h4C;
   localparam logic [7:0] C_SWITCH = 8'h4D;
   localparam logic [7:0] C_OVLD = 8'h4F;
   localparam logic [7:0] C_RANGE = 8'h52;
   localparam logic [7:0] C_STATUS = 8'h53;
   localparam logic [7:0] C_THRESH = 8'h54;
   localparam logic [7:0] C_UNIT = 8'h55;
   localparam logic [7:0] C_INTEG = 8'h56;
   localparam logic [7:0] C_FILTER = 8'h58;
   localparam logic [7:0] C_LAST = 8'h3F;
   // Field limits.
   localparam int MAX_LEN = 150;
   localparam logic [7:0] NUM_CH = 8'h10;
   localparam logic [7:0] MAX_ADDR = 8'h10;
   localparam logic [7:0] DEF_ADDR = 8'h01;
   localparam logic [7:0] THR_MIN = 8'h01;
   localparam logic [7:0] THR_MAX = 8'h0A;
   localparam logic [7:0] BANK_MIN = 8'h01;
   localparam logic [7:0] BANK_MAX = 8'h04;
   localparam logic [7:0] GAIN_1 = 8'h01;
   localparam logic [7:0] GAIN_10 = 8'h0A;
   localparam logic [7:0] GAIN_100 = 8'h64;
   localparam logic [7:0] OPT_ON = 8'h01;
   localparam logic [1:0] ADDR_DIG_MAX = 2'h2;
   // Parser field phases.
   localparam logic [1:0] PH_PRE = 2'h0;
   localparam logic [1:0] PH_CHAN = 2'h1;
   localparam logic [1:0] PH_SEL = 2'h2;
   localparam logic [1:0] PH_DONE = 2'h3;
   // Layout of a decoded command word.
   localparam int SEL_LSB = 0;
   localparam int CHAN_LSB = 8;
   localparam int CODE_LSB = 16;
   localparam int HAS_SEL_BIT = 24;
   localparam int QUERY_BIT = 25;
   localparam int RESP_BIT = 26;
   localparam int GLOB_BIT = 27;
   localparam int ERR_BIT = 28;
   localparam int CW_W = 29;
   // Power-on lamp flashing.
   localparam int FLASH_TIMES = 3;
   localparam int FLASH_HALF_MS = 250;
   localparam int CLK_KHZ = 250000;
   localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;
endpackage

// file: core/cmd_skid_buf.sv
// Two-entry buffer between the parser and the command consumer.
`timescale 1ns/1ps
module cmd_skid_buf #(
   parameter int W = 8
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic out_v_q;
   logic skid_v_q;
   logic [W-1:0] out_q;
   logic [W-1:0] skid_q;
   wire drain = out_ready | ~out_v_q;
   wire take = in_valid & ~skid_v_q;

   generate
      if (W < 1) begin : g_chk
         $error("cmd_skid_buf needs a positive width");
      end
   endgenerate

   // The skid entry catches the word that arrives during a stall.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         out_v_q <= 1'b0;
         skid_v_q <= 1'b0;
         out_q <= '0;
         skid_q <= '0;
      end else if (drain) begin
         out_v_q <= skid_v_q | take;
         out_q <= skid_v_q ? skid_q : (take ? in_data : out_q);
         skid_v_q <= 1'b0;
      end else if (take) begin
         skid_q <= in_data;
         skid_v_q <= 1'b1;
      end
   end

   assign in_ready = ~skid_v_q;
   assign out_valid = out_v_q;
   assign out_data = out_q;
endmodule // cmd_skid_buf

// file: core/lamp_flasher.sv
// Power-on flashing of the front-panel lamps.
`timescale 1ns/1ps
module lamp_flasher #(
   parameter int unsigned HALF_CYC = 62500000,
   parameter int TIMES = 3
) (
   input wire logic ref_clk,
   input wire logic resetn,
   output logic lamp_on
);
   logic [31:0] tick_q;
   logic [7:0] half_q;
   logic lamp_q;
   wire run = half_q < 8'(2 * TIMES);
   wire tick_end = tick_q == HALF_CYC - 1;

   generate
      if (HALF_CYC < 1 || TIMES < 1 || TIMES > 100) begin : g_chk
         $error("lamp_flasher parameters out of range");
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tick_q <= 32'h0;
         half_q <= 8'h00;
         lamp_q <= 1'b0;
      end else if (run) begin
         tick_q <= tick_end ? 32'h0 : tick_q + 32'h1;
         if (tick_end) begin
            half_q <= half_q + 8'h01;
            lamp_q <= ~lamp_q;
         end
      end
   end

   assign lamp_on = lamp_q;
endmodule // lamp_flasher

// file: core/rack_cmd_parser.sv
// Command string parser for one conditioner rack on the shared serial link.
`timescale 1ns/1ps
// How it works
// - Command text only, no extra characters.
// - Command letters accepted in either case.
// - Sixteen one-character command codes decoded.
// - Overload threshold selection from 1 to 10.
// - Backup and install use banks 1 to 4.
// - Fields: address, code, channel, selection.
// - Missing address means rack one.
// - Address is 1-2 digits, colon, 1..16; range not checked, only compared with own_q.
// - Address zero is global, all racks act.
// - Global: only rack one answers, afterwards.
// - Channel zero means all, where permitted.
// - Selection follows an equals sign.
// - Gain selection is 1, 10 or 100.
// - Option switches: 0 off, 1 on.
// - Trailing question mark makes a status request.
// - Semicolons separate commands, run in order.
// - Nothing acts before CR then LF.
// - No status requests in multi-command strings.
// - Stray line feeds are ignored harmlessly.
// - Lamps flash three times at power-on.
// - CR is 13, LF is 10.
// - Spaces allowed, backspace removes last character.
// - At most 150 characters up to CR.
module rack_cmd_parser
   import rack_cmd_pkg::*;
#(
   parameter int LINE_LEN = rack_cmd_pkg::MAX_LEN,
   parameter int unsigned FLASH_CYC = rack_cmd_pkg::FLASH_HALF_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [4:0] own_addr_pin,
   output logic cmd_valid,
   input wire logic cmd_ready,
   output logic [7:0] cmd_code,
   output logic [7:0] cmd_chan,
   output logic [7:0] cmd_sel,
   output logic cmd_has_sel,
   output logic cmd_query,
   output logic cmd_respond,
   output logic cmd_global,
   output logic cmd_error,
   output logic lamp_flash
);
   import rack_cmd_pkg::*;

   localparam int PW = $clog2(LINE_LEN + 1);

   typedef enum logic [3:0] {
      S_RECV = 4'b0001,
      S_WAITLF = 4'b0010,
      S_PARSE = 4'b0100,
      S_EMIT = 4'b1000
   } state_t;

   generate
      if (LINE_LEN < 2 || LINE_LEN > 255) begin : g_chk
         $error("rack_cmd_parser line length out of range");
      end
   endgenerate

   function automatic logic [7:0] upcase(input logic [7:0] c);
      return (c >= CH_LOW_A && c <= CH_LOW_Z) ? (c & ~CASE_BIT) : c;
   endfunction

   function automatic logic is_digit(input logic [7:0] c);
      return c >= CH_D0 && c <= CH_D9;
   endfunction

   function automatic logic code_ok(input logic [7:0] c);
      unique case (c)
         C_GAIN, C_BACKUP, C_CALIN, C_COUPLE, C_FAULT, C_INSTALL,
         C_LAMP, C_SWITCH, C_OVLD, C_RANGE, C_STATUS, C_THRESH,
         C_UNIT, C_INTEG, C_FILTER, C_LAST: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // Only per-channel settings that make sense for all channels take 0.
   function automatic logic ch0_ok(input logic [7:0] c);
      return c == C_GAIN || c == C_FILTER || c == C_INTEG;
   endfunction

   function automatic logic sel_ok(input logic [7:0] c,
                                   input logic [7:0] v);
      unique case (c)
         C_GAIN: return v == GAIN_1 || v == GAIN_10 || v == GAIN_100;
         C_THRESH: return v >= THR_MIN && v <= THR_MAX;
         C_BACKUP, C_INSTALL: return v >= BANK_MIN && v <= BANK_MAX;
         C_CALIN, C_COUPLE, C_LAMP, C_RANGE, C_FILTER, C_INTEG:
            return v <= OPT_ON;
         C_SWITCH: return v <= NUM_CH;
         C_UNIT: return v >= DEF_ADDR && v <= MAX_ADDR;
         default: return 1'b1;
      endcase
   endfunction

   state_t st_q;
   logic rx_ready_q;
   logic [7:0] line_q [LINE_LEN];
   logic [PW-1:0] len_q;
   logic [PW-1:0] ptr_q;
   logic ovf_q;
   logic [7:0] semi_q;
   logic last_q;
   logic [4:0] own_s1_q;
   logic [4:0] own_s2_q;
   logic [4:0] own_s3_q;
   logic [4:0] own_q;
   logic [1:0] ph_q;
   logic [7:0] num_q;
   logic [1:0] nd_q;
   logic [7:0] addr_q;
   logic has_addr_q;
   logic [7:0] code_q;
   logic [7:0] chan_q;
   logic [1:0] chnd_q;
   logic query_q;
   logic fmt_q;
   logic buf_ready;
   logic [CW_W-1:0] buf_out;

   // Receive-side decode.
   wire rx_fire = rx_valid & rx_ready_q;
   wire recv = st_q == S_RECV;
   wire is_cr = rx_data == CH_CR;
   wire is_lf = rx_data == CH_LF;
   wire is_bs = rx_data == CH_BS;
   wire is_sp = rx_data == CH_SP;
   wire plain = ~is_cr & ~is_lf & ~is_bs & ~is_sp;
   wire full = len_q == PW'(LINE_LEN);
   wire store = rx_fire & recv & plain & ~full;

   // Parse-side decode.
   wire [7:0] pc = upcase(line_q[ptr_q]);
   wire at_end = ptr_q == len_q;
   wire seg_end = at_end | (pc == CH_SEMI);
   wire pdig = is_digit(pc);
   wire [11:0] acc_w = 12'(num_q) * 12'd10 + 12'(pc - CH_D0);
   wire [7:0] acc = (acc_w > 12'hFF) ? 8'hFF : acc_w[7:0];
   wire [1:0] nd_inc = (nd_q == 2'h3) ? nd_q : nd_q + 2'h1;

   // Final field values of the segment just closed.
   wire in_chan = ph_q == PH_CHAN;
   wire has_sel = ph_q == PH_SEL;
   wire [7:0] fin_chan = in_chan ? num_q : chan_q;
   wire [1:0] fin_chnd = in_chan ? nd_q : chnd_q;
   wire [7:0] fin_sel = has_sel ? num_q : 8'h00;
   wire seg_empty = ph_q == PH_PRE && nd_q == 2'h0 && !has_addr_q;
   wire glob = has_addr_q && addr_q == 8'h00;
   wire [7:0] target = has_addr_q ? addr_q : DEF_ADDR;
   wire mine = glob || target == {3'h0, own_q};
   wire query = query_q || code_q == C_LAST;
   wire code_bad = !code_ok(code_q);
   wire ch_zero_bad = fin_chan == 8'h00 && !ch0_ok(code_q);
   wire ch_bad = fin_chnd != 2'h0 && (fin_chan > NUM_CH || ch_zero_bad);
   wire sel_bad = query ? has_sel
      : (!has_sel || nd_q == 2'h0 || !sel_ok(code_q, fin_sel));
   wire mq_bad = query && semi_q != 8'h00;
   wire seg_err = fmt_q | (ph_q == PH_PRE) | code_bad | ch_bad
                  | sel_bad | mq_bad;
   wire resp = !glob || own_q == DEF_ADDR[4:0];
   wire emit = st_q == S_EMIT;
   wire want = emit & ~seg_empty & mine;
   wire push = want & buf_ready;
   wire seg_done = emit & (~want | buf_ready);

   wire [CW_W-1:0] word = {seg_err, glob, resp, query, has_sel,
                           code_q, fin_chan, fin_sel};

   // Three-stage strap capture; a change counts once stages agree.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         own_s1_q <= 5'h00;
         own_s2_q <= 5'h00;
         own_s3_q <= 5'h00;
         own_q <= DEF_ADDR[4:0];
      end else begin
         own_s1_q <= own_addr_pin;
         own_s2_q <= own_s1_q;
         own_s3_q <= own_s2_q;
         if (own_s2_q == own_s3_q) begin
            own_q <= own_s3_q;
         end
      end
   end

   // The line store is plain data and needs no reset.
   always_ff @(posedge ref_clk) begin
      if (store) begin
         line_q[len_q] <= rx_data;
      end
   end

   // Line assembly and the top-level sequence.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= S_RECV;
         rx_ready_q <= 1'b0;
         len_q <= '0;
         ptr_q <= '0;
         ovf_q <= 1'b0;
         semi_q <= 8'h00;
         last_q <= 1'b0;
      end else begin
         rx_ready_q <= 1'b0;
         unique case (st_q)
            S_RECV: begin
               rx_ready_q <= 1'b1;
               if (rx_fire) begin
                  if (is_cr) begin
                     st_q <= S_WAITLF;
                     rx_ready_q <= 1'b1;
                  end else if (is_bs && len_q != '0) begin
                     len_q <= len_q - PW'(1);
                  end else if (plain && full) begin
                     ovf_q <= 1'b1;
                  end else if (store) begin
                     len_q <= len_q + PW'(1);
                     if (rx_data == CH_SEMI) begin
                        semi_q <= semi_q + 8'h01;
                     end
                  end
               end
            end
            S_WAITLF: begin
               rx_ready_q <= 1'b1;
               if (rx_fire) begin
                  // Anything but LF after CR discards the whole string.
                  if (is_lf && !ovf_q && len_q != '0) begin
                     st_q <= S_PARSE;
                     rx_ready_q <= 1'b0;
                     ptr_q <= '0;
                  end else begin
                     st_q <= S_RECV;
                     len_q <= '0;
                     semi_q <= 8'h00;
                     ovf_q <= 1'b0;
                  end
               end
            end
            S_PARSE: begin
               if (seg_end) begin
                  st_q <= S_EMIT;
                  last_q <= at_end;
               end
               if (!at_end) begin
                  ptr_q <= ptr_q + PW'(1);
               end
            end
            S_EMIT: begin
               if (seg_done) begin
                  st_q <= last_q ? S_RECV : S_PARSE;
                  rx_ready_q <= last_q;
                  if (last_q) begin
                     len_q <= '0;
                     semi_q <= 8'h00;
                  end
               end
            end
         endcase
      end
   end

   // Field splitting of one command, a character per cycle.
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ph_q <= PH_PRE;
         num_q <= 8'h00;
         nd_q <= 2'h0;
         addr_q <= 8'h00;
         has_addr_q <= 1'b0;
         code_q <= 8'h00;
         chan_q <= 8'h00;
         chnd_q <= 2'h0;
         query_q <= 1'b0;
         fmt_q <= 1'b0;
      end else if (seg_done) begin
         ph_q <= PH_PRE;
         num_q <= 8'h00;
         nd_q <= 2'h0;
         has_addr_q <= 1'b0;
         chnd_q <= 2'h0;
         query_q <= 1'b0;
         fmt_q <= 1'b0;
      end else if (st_q == S_PARSE && !seg_end) begin
         if (pdig && ph_q != PH_DONE) begin
            num_q <= acc;
            nd_q <= nd_inc;
         end else begin
            num_q <= 8'h00;
            nd_q <= 2'h0;
            unique case (ph_q)
               PH_PRE: begin
                  if (pc == CH_COLON) begin
                     addr_q <= num_q;
                     has_addr_q <= 1'b1;
                     if (has_addr_q || nd_q == 2'h0
                         || nd_q > ADDR_DIG_MAX) begin
                        fmt_q <= 1'b1;
                     end
                  end else begin
                     code_q <= pc;
                     ph_q <= PH_CHAN;
                     fmt_q <= fmt_q | (nd_q != 2'h0);
                  end
               end
               PH_CHAN: begin
                  chan_q <= num_q;
                  chnd_q <= nd_q;
                  if (pc == CH_EQ) begin
                     ph_q <= PH_SEL;
                  end else if (pc == C_LAST) begin
                     ph_q <= PH_DONE;
                     query_q <= 1'b1;
                  end else begin
                     fmt_q <= 1'b1;
                  end
               end
               PH_SEL, PH_DONE: fmt_q <= 1'b1;
            endcase
         end
      end
   end

   cmd_skid_buf #(.W(CW_W)) u_buf (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .in_valid(want),
      .in_ready(buf_ready),
      .in_data(word),
      .out_valid(cmd_valid),
      .out_ready(cmd_ready),
      .out_data(buf_out)
   );

   lamp_flasher #(.HALF_CYC(FLASH_CYC), .TIMES(FLASH_TIMES)) u_lamp (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .lamp_on(lamp_flash)
   );

   assign rx_ready = rx_ready_q;
   assign cmd_sel = buf_out[SEL_LSB +: 8];
   assign cmd_chan = buf_out[CHAN_LSB +: 8];
   assign cmd_code = buf_out[CODE_LSB +: 8];
   assign cmd_has_sel = buf_out[HAS_SEL_BIT];
   assign cmd_query = buf_out[QUERY_BIT];
   assign cmd_respond = buf_out[RESP_BIT];
   assign cmd_global = buf_out[GLOB_BIT];
   assign cmd_error = buf_out[ERR_BIT];

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   lf_idle_a: assert property (recv && rx_fire && is_lf |=>
      st_q == S_RECV && len_q == $past(len_q))
      else $error("stray line feed changed the line");
   bs_a: assert property (recv && rx_fire && is_bs && len_q != '0 |=>
      len_q == $past(len_q) - PW'(1))
      else $error("backspace did not remove a character");
   sp_a: assert property (recv && rx_fire && is_sp |=>
      len_q == $past(len_q))
      else $error("space was stored");
   len_a: assert property (len_q <= PW'(LINE_LEN))
      else $error("line longer than its limit");
   crlf_a: assert property (st_q == S_PARSE
      && $past(st_q) != S_PARSE && $past(st_q) != S_EMIT
      |-> $past(st_q) == S_WAITLF && $past(is_lf))
      else $error("parse started without CR LF");
   glob_a: assert property (push && glob
      |-> resp == (own_q == 5'h01))
      else $error("global answer from wrong rack");
   mine_a: assert property (want |-> mine)
      else $error("foreign command was passed on");
   multi_a: assert property (push && query
      |-> seg_err || semi_q == 8'h00)
      else $error("status request accepted in a multi-command string");
   case_a: assert property (push && !seg_err |->
      !(code_q >= CH_LOW_A && code_q <= CH_LOW_Z))
      else $error("lower-case code was not folded");
   stall_a: assert property (want && !buf_ready |=> st_q == S_EMIT)
      else $error("command lost during a stall");

   glob_c: cover property (push && glob && !seg_err);
   query_c: cover property (push && query && !seg_err);
   multi_c: cover property (push && semi_q != 8'h00 && !last_q);
   stall_c: cover property (cmd_valid && !cmd_ready && !buf_ready);
endmodule // rack_cmd_parser

// file: dv/host_link_model.sv
// Host side of the serial link: offers command characters one at a time.
`timescale 1ns/1ps
module host_link_model (
   input wire logic ref_clk,
   input wire logic resetn,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready
);
   initial begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
   end
   // Sends the bare text then CR LF; gap idles between characters.
   task automatic send(input string s, input int gap);
      string t;
      int n;
      t = {s, "\015\012"};
      for (int i = 0; i < t.len(); i++) begin
         @(negedge ref_clk);
         rx_data = t[i];
         rx_valid = 1'b1;
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (rx_ready !== 1'b1 && n < 2000);
         for (int g = 0; g < gap; g++) begin
            @(negedge ref_clk);
            rx_valid = 1'b0;
            // Idle data keeps changing so a stale character is never seen.
            rx_data = ~rx_data;
         end
      end
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask
endmodule // host_link_model

// file: dv/test_rack_cmd_parser.sv
// Self-checking bench for the rack command parser.
`timescale 1ns/1ps
module test_rack_cmd_parser;
   import rack_cmd_pkg::*;
   localparam int LL = 20;
   localparam logic [28:0] ALL = 29'h1FFFFFFF;
   localparam logic [7:0] CODES [16] = '{C_GAIN, C_BACKUP, C_CALIN,
      C_COUPLE, C_FAULT, C_INSTALL, C_LAMP, C_SWITCH, C_OVLD, C_RANGE,
      C_STATUS, C_THRESH, C_UNIT, C_INTEG, C_FILTER, C_LAST};
   logic ref_clk, resetn, rx_valid, rx_ready, cmd_valid, cmd_ready;
   logic [7:0] rx_data, cmd_code, cmd_chan, cmd_sel;
   logic [4:0] own_addr_pin;
   logic cmd_has_sel, cmd_query, cmd_respond, cmd_global, cmd_error;
   logic lamp_flash;
   int n_mismatch = 0;
   int checks_done = 0;
   int lamp_rises = 0;
   wire [28:0] word = {cmd_code, cmd_chan, cmd_sel, cmd_has_sel,
      cmd_query, cmd_respond, cmd_global, cmd_error};

   // Short lamp period keeps the power-on flashing inside the run.
   rack_cmd_parser #(.LINE_LEN(LL), .FLASH_CYC(4)) rack_cmd_parser_i (
      .ref_clk(ref_clk), .resetn(resetn), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_ready(rx_ready),
      .own_addr_pin(own_addr_pin), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_chan(cmd_chan),
      .cmd_sel(cmd_sel), .cmd_has_sel(cmd_has_sel),
      .cmd_query(cmd_query), .cmd_respond(cmd_respond),
      .cmd_global(cmd_global), .cmd_error(cmd_error),
      .lamp_flash(lamp_flash));
   host_link_model host_link_model_i (.ref_clk(ref_clk), .resetn(resetn),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   always @(posedge lamp_flash) lamp_rises++;

   task automatic conclude;
      $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [28:0] ew(logic [7:0] c, logic [7:0] ch,
                                      logic [7:0] s, logic [4:0] f);
      return {c, ch, s, f};
   endfunction

   // Takes one word from the parser and compares the bits under the mask.
   task automatic take(input logic [28:0] e, input logic [28:0] m);
      int n;
      n = 0;
      @(negedge ref_clk);
      cmd_ready = 1'b1;
      while (cmd_valid !== 1'b1 && n < 400) begin
         @(negedge ref_clk);
         n++;
      end
      check({3'h0, word & m}, {3'h0, e & m});
      @(negedge ref_clk);
      cmd_ready = 1'b0;
   endtask

   task automatic no_word;
      logic seen;
      seen = 1'b0;
      repeat (80) @(negedge ref_clk) if (cmd_valid !== 1'b0) seen = 1'b1;
      check({31'h0, seen}, 32'h0);
   endtask

   task automatic set_addr(input logic [4:0] a);
      @(negedge ref_clk);
      own_addr_pin = a;
      repeat (5) @(negedge ref_clk);
   endtask

   task automatic t_lamp;
      repeat (100) @(negedge ref_clk);
      check(lamp_rises, 3);
      check({31'h0, lamp_flash}, 32'h0);
   endtask

   task automatic t_basic;
      host_link_model_i.send("A1=1", 0);
      take(ew(C_GAIN, 8'h01, GAIN_1, 5'b10100), ALL);
      host_link_model_i.send("a1 5 = 100", 3);
      take(ew(C_GAIN, 8'h0F, GAIN_100, 5'b10100), ALL);
   endtask

   task automatic t_codes;
      string s;
      for (int k = 0; k < 16; k++) begin
         s = "Z?";
         s.putc(0, CODES[k]);
         if (CODES[k] == C_LAST) s = "?";
         host_link_model_i.send(s, 0);
         take(ew(CODES[k], 8'h00, 8'h00, 5'b01100), ALL);
      end
   endtask

   task automatic t_multi;
      set_addr(5'h02);
      host_link_model_i.send("2:L=1; 2:R=1;2:a3=10", 0);
      repeat (40) @(negedge ref_clk);
      // Three words against a two-entry buffer: intake must stay closed.
      check({31'h0, rx_ready}, 32'h0);
      take(ew(C_LAMP, 8'h00, OPT_ON, 5'b10100), ALL);
      take(ew(C_RANGE, 8'h00, OPT_ON, 5'b10100), ALL);
      take(ew(C_GAIN, 8'h03, GAIN_10, 5'b10100), ALL);
      host_link_model_i.send("00:L=1", 0);
      take(ew(C_LAMP, 8'h00, OPT_ON, 5'b10010), ALL);
      set_addr(5'h01);
      host_link_model_i.send("0:L=1", 0);
      take(ew(C_LAMP, 8'h00, OPT_ON, 5'b10110), ALL);
      host_link_model_i.send("3:L=1", 0);
      no_word();
   endtask

   task automatic t_reject;
      string rs [11] = '{"T=11", "T=10", "T=0", "B=5", "I=4", "C=2",
         "D=0", "A1=5", "L0=1", "X0=1", "Z=1"};
      logic re [11] = '{1, 0, 1, 1, 0, 1, 0, 1, 1, 0, 1};
      for (int k = 0; k < 11; k++) begin
         host_link_model_i.send(rs[k], 0);
         take({28'h0, re[k]}, 29'h1);
      end
   endtask

   task automatic t_line;
      host_link_model_i.send("\012\012A1=1\015X", 0);
      no_word();
      host_link_model_i.send("A29\010=10", 0);
      take(ew(C_GAIN, 8'h02, GAIN_10, 5'b10100), ALL);
      host_link_model_i.send("A1?;L=1", 0);
      take(29'h1, 29'h1);
      take(29'h0, 29'h1);
      host_link_model_i.send("A1=1;A1=1;A1=1;A1=10", 0);
      for (int k = 0; k < 3; k++) begin
         take(ew(C_GAIN, 8'h01, GAIN_1, 5'b10100), ALL);
      end
      take(ew(C_GAIN, 8'h01, GAIN_10, 5'b10100), ALL);
      host_link_model_i.send("A1=1;A1=1;A1=1;A1=100", 0);
      no_word();
   endtask

   initial begin
      #120000;
      n_mismatch++;
      conclude();
   end

   initial begin
      resetn = 1'b0;
      cmd_ready = 1'b0;
      own_addr_pin = 5'h01;
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk);
      resetn = 1'b1;
      t_lamp();
      t_basic();
      t_codes();
      t_multi();
      t_reject();
      t_line();
      conclude();
   end
endmodule // test_rack_cmd_parser
